// file: design/fsr_pkg.sv
// constants and types for the region, reset and parameter-table command block
package fsr_pkg;
  // command opcodes
  localparam logic [7:0] OP_PARAM_READ      = 8'h5A;
  localparam logic [7:0] OP_RESET_ARM       = 8'h66;
  localparam logic [7:0] OP_RESET_FIRE      = 8'h99;
  localparam logic [7:0] OP_REGION_ERASE    = 8'h44;
  localparam logic [7:0] OP_REGION_PROG     = 8'h42;
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;

  // timing, each time in its own unit and its cycle count derived
  localparam int unsigned CLK_PERIOD_NS         = 25;
  localparam int unsigned RESET_PULSE_TIME_NS   = 100;
  localparam int unsigned SECTOR_ERASE_TIME_US  = 50000;
  localparam int unsigned PAGE_PROGRAM_TIME_US  = 800;
  localparam int unsigned RECOVER_TIME_NS       = 1000;
  localparam int unsigned RECOVER_WRITE_TIME_NS = 10000;
  localparam int unsigned RST_CYC    = (RESET_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CYC  = SECTOR_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYC   = PAGE_PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned REC_CYC    = (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_WR_CYC = (RECOVER_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // frame bit counts on the link
  localparam int          CNT_W          = 12;
  localparam logic [11:0] BITS_CMD       = 12'h008;
  localparam logic [11:0] BITS_ADDR_END  = 12'h020;
  localparam logic [11:0] BITS_PROG_MIN  = 12'h028;
  localparam logic [11:0] DUMMY_BITS_SPI = 12'h008;
  localparam logic [11:0] DUMMY_BITS_QPI = 12'h020;
  localparam logic [11:0] CNT_SAT        = 12'hFF0;
  localparam logic [11:0] STEP_SPI       = 12'h001;
  localparam logic [11:0] STEP_QPI       = 12'h004;

  // address fields of the information regions
  localparam int         ADDR_TOP_LSB   = 16;
  localparam int         REGION_SEL_LSB = 12;
  localparam int         REGION_GAP_LSB = 10;
  localparam logic [7:0] ADDR_TOP_ZERO  = 8'h00;
  localparam logic [1:0] GAP_ZERO       = 2'h0;
  localparam logic [3:0] REGION_SEL_1   = 4'h1;
  localparam logic [3:0] REGION_SEL_2   = 4'h2;
  localparam logic [3:0] REGION_SEL_3   = 4'h3;
  localparam int         REGION_COUNT   = 3;
  localparam int         REGION_AW      = 10;
  localparam int         MEM_AW         = 12;
  localparam int         MEM_BYTES      = 3072;
  localparam logic [9:0] REGION_LAST    = 10'h3FF;
  localparam logic [8:0] PAGE_BYTES     = 9'h100;

  // status-register-2 lock field and configuration
  localparam int         LOCK_LSB      = 11;
  localparam int         CFG_W         = 8;
  localparam logic [7:0] VOLCFG_RESET  = 8'h00;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  localparam logic [7:0] UNDEF_BYTE    = 8'hFF;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_RECOV} fsr_state_t;
endpackage

// file: design/fsr_ctrl.sv
// command block: parameter-table read, resets and one-time-lockable regions
`timescale 1ns/10ps
module fsr_ctrl #(
  parameter int unsigned ERASE_CYCLES  = fsr_pkg::ERASE_CYC, // erase cycle length
  parameter int unsigned PROG_CYCLES   = fsr_pkg::PROG_CYC,  // program cycle length
  parameter bit          DEDICATED_RST = 1'b1                // reset pin not shared
) (
  input  wire logic                     clk,           // core clock, 40 MHz
  input  wire logic                     rst_n,         // async reset, active low
  input  wire logic                     ce,            // core clock enable
  input  wire logic                     sck,           // link clock from host
  input  wire logic                     csN,           // chip select, active low
  input  wire logic [3:0]               ioIn,          // data pins in
  output logic      [3:0]               ioOut,         // data pins out
  output logic      [3:0]               ioOe,          // data pin enables
  input  wire logic                     qpiMode,       // four-wire command mode
  input  wire logic                     quadIoEnable,  // quad enable bit
  input  wire logic                     pinSelReset,   // shared pin set to reset
  input  wire logic                     dedRstDisable, // dedicated pin disabled
  input  wire logic                     hwResetN,      // reset pin, active low
  input  wire logic [15:0]              sr2In,         // status register 2 copy
  input  wire logic                     extBusy,       // other write cycle running
  input  wire logic [fsr_pkg::CFG_W-1:0] nvCfg,        // nonvolatile configuration
  output logic      [fsr_pkg::CFG_W-1:0] volCfg,       // volatile configuration
  output logic                          readParamRst,  // clear read parameters
  output logic                          busyFlag,      // cycle in progress
  output logic                          writeLatchFlag, // write latch
  input  wire logic [fsr_pkg::MEM_AW-1:0] rdAddr,      // region array read address
  output logic      [7:0]               rdData         // region array read data
);
  import fsr_pkg::*;

  function automatic logic [1:0] regionOf(input logic [23:0] a);
    logic [1:0] r;
    r = 2'd0;
    if (a[ADDR_TOP_LSB +: 8] == ADDR_TOP_ZERO && a[REGION_GAP_LSB +: 2] == GAP_ZERO) begin
      if (a[REGION_SEL_LSB +: 4] == REGION_SEL_1) r = 2'd1;
      if (a[REGION_SEL_LSB +: 4] == REGION_SEL_2) r = 2'd2;
      if (a[REGION_SEL_LSB +: 4] == REGION_SEL_3) r = 2'd3;
    end
    return r;
  endfunction

  function automatic logic [7:0] tableByte(input logic [7:0] a);
    logic [7:0] b;
    b = UNDEF_BYTE;
    unique case (a)
      8'h00: b = 8'h53;
      8'h01: b = 8'h46;
      8'h02: b = 8'h44;
      8'h03: b = 8'h50;
      8'h04: b = 8'h06;
      8'h05: b = 8'h01;
      8'h06: b = 8'h00;
      8'h07: b = 8'hFF;
      8'h08: b = 8'h00;
      8'h09: b = 8'h06;
      8'h0A: b = 8'h01;
      8'h0B: b = 8'h10;
      8'h0C: b = 8'h30;
      8'h0D: b = 8'h00;
      8'h0E: b = 8'h00;
      8'h0F: b = 8'hFF;
      default: b = UNDEF_BYTE;
    endcase
    return b;
  endfunction

  // ---------------- link domain (sck) ----------------
  logic             frmStart_r;
  logic             frmTog_r;
  logic             qpiS1_r, qpiS2_r;
  logic [CNT_W-1:0] bitCnt_r;
  logic [31:0]      shift_r;
  logic [7:0]       opcode_r;
  logic [23:0]      addr_r;
  logic [3:0]       outNib_r;
  logic [3:0]       oeLink_r;
  logic [7:0]       pageBuf [0:255];

  // chip select high flags a new frame and clears the output drive without any sck edge
  wire              linkRst  = csN | ~rst_n;
  wire [CNT_W-1:0]  stepBits = qpiS2_r ? STEP_QPI : STEP_SPI;
  wire [CNT_W-1:0]  cntBase  = frmStart_r ? '0 : bitCnt_r;
  wire [CNT_W-1:0]  cntNxt   = (cntBase >= CNT_SAT) ? cntBase : cntBase + stepBits;
  wire [31:0]       shNxt    = qpiS2_r ? {shift_r[27:0], ioIn} : {shift_r[30:0], ioIn[0]};
  wire              byteDone = (cntNxt > BITS_ADDR_END) && (cntNxt[2:0] == 3'd0);
  wire [7:0]        bufWrIdx = 8'(addr_r[7:0] + cntNxt[10:3] - 8'd5);
  wire [CNT_W-1:0]  dataStart = BITS_ADDR_END + (qpiS2_r ? DUMMY_BITS_QPI : DUMMY_BITS_SPI);
  wire [CNT_W-1:0]  outPos    = bitCnt_r - dataStart;
  wire [7:0]        outByte   = tableByte(8'(addr_r[7:0] + outPos[10:3]));
  wire              inData    = (opcode_r == OP_PARAM_READ) && (bitCnt_r >= dataStart);
  wire [3:0]        outNxt    = qpiS2_r ? (outPos[2] ? outByte[3:0] : outByte[7:4])
                                        : {2'b00, outByte[3'd7 - outPos[2:0]], 1'b0};

  always_ff @(posedge sck or posedge linkRst) begin
    if (linkRst) frmStart_r <= 1'b1;
    else         frmStart_r <= 1'b0;
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      qpiS1_r  <= 1'b0;
      qpiS2_r  <= 1'b0;
      frmTog_r <= 1'b0;
      bitCnt_r <= '0;
      shift_r  <= '0;
      opcode_r <= '0;
      addr_r   <= '0;
    end else begin
      qpiS1_r  <= qpiMode;
      qpiS2_r  <= qpiS1_r;
      bitCnt_r <= cntNxt;
      shift_r  <= shNxt;
      if (frmStart_r) frmTog_r <= ~frmTog_r;
      if (cntNxt == BITS_CMD) opcode_r <= shNxt[7:0];
      if (cntNxt == BITS_ADDR_END) addr_r <= shNxt[23:0];
    end
  end

  // program data lands at its in-page position; later bytes overwrite earlier ones
  always_ff @(posedge sck) begin
    if (byteDone) pageBuf[bufWrIdx] <= shNxt[7:0];
  end

  always_ff @(negedge sck or posedge linkRst) begin
    if (linkRst) begin
      outNib_r <= 4'h0;
      oeLink_r <= 4'h0;
    end else if (inData && !frmStart_r) begin
      outNib_r <= outNxt;
      oeLink_r <= qpiS2_r ? 4'hF : 4'h2;
    end
  end

  // ---------------- core domain (clk) ----------------
  logic             csS1_r, csS2_r, csPrev_r;
  logic             togS1_r, togS2_r, togSeen_r;
  logic             hwS1_r, hwS2_r;
  logic [2:0]       hwCnt_r;
  logic             spoiled_r;
  logic             armed_r;
  logic             wel_r;
  fsr_state_t       state_r;
  logic [31:0]      timer_r;
  logic [9:0]       idx_r;
  logic [8:0]       progN_r;
  logic [7:0]       progLow_r;
  logic [1:0]       page_r;
  logic [1:0]       region_r;
  logic             wasWrite;
  logic [CFG_W-1:0] volCfg_r;
  logic             readParamRst_r;
  logic [7:0]       rdData_r;
  logic [7:0]       regionMem [0:MEM_BYTES-1];

  wire        hwEn      = DEDICATED_RST ? ~dedRstDisable
                                        : (pinSelReset & ~qpiMode & ~quadIoEnable);
  wire        hwHold    = (hwCnt_r >= 3'(RST_CYC));
  wire        csRise    = csS2_r & ~csPrev_r;
  // link registers are stable here: sck stopped and select seen high twice
  wire        frmOk     = ce & csRise & (togS2_r != togSeen_r) & ~spoiled_r & ~hwHold;
  wire [7:0]  frmOp     = opcode_r;
  wire [23:0] frmAddr   = addr_r;
  wire [11:0] frmBits   = bitCnt_r;
  wire [1:0]  frmRegion = regionOf(frmAddr);
  wire [2:0]  lockVec   = sr2In[LOCK_LSB +: REGION_COUNT];
  wire        frmLocked = (frmRegion != 2'd0) && lockVec[2'(frmRegion - 2'd1)];
  wire        busyAny   = (state_r != ST_IDLE) | extBusy;
  wire        wrOk       = frmOk & wel_r & ~busyAny & (frmRegion != 2'd0) & ~frmLocked;
  wire        startErase = wrOk && frmOp == OP_REGION_ERASE && frmBits == BITS_ADDR_END;
  wire        startProg  = wrOk && frmOp == OP_REGION_PROG && frmBits >= BITS_PROG_MIN;
  wire        weSet      = frmOk && frmOp == OP_WRITE_LATCH_SET && frmBits == BITS_CMD
                           && !busyAny;
  wire        armSet     = frmOk && frmOp == OP_RESET_ARM && frmBits == BITS_CMD;
  wire        swFire     = frmOk && frmOp == OP_RESET_FIRE && frmBits == BITS_CMD && armed_r;
  wire        abort      = swFire | (ce & hwHold);
  wire [8:0]  frmBytes   = 9'(frmBits[11:3] - 9'd4);
  wire [8:0]  keepBytes  = (frmBytes > PAGE_BYTES) ? PAGE_BYTES : frmBytes;
  // page and offset from bits 9-0
  wire [7:0]  progIdx    = 8'(progLow_r + idx_r[7:0]);
  wire [MEM_AW-1:0] memAddr = {2'(region_r - 2'd1), (state_r == ST_PROG) ? {page_r, progIdx}
                                                                          : idx_r};
  wire        eraseWe    = (state_r == ST_ERASE) && (idx_r != REGION_LAST || timer_r != '0);
  wire        progWe     = (state_r == ST_PROG) && ({1'b0, idx_r[7:0]} < progN_r)
                           && (idx_r[9:8] == 2'b00);
  wire [7:0]  memWData   = (state_r == ST_ERASE) ? ERASED_BYTE
                                                 : (regionMem[memAddr] & pageBuf[progIdx]);
  wire        memWe      = ce & ~abort & (eraseWe | progWe);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csS1_r    <= 1'b1;
      csS2_r    <= 1'b1;
      csPrev_r  <= 1'b1;
      togS1_r   <= 1'b0;
      togS2_r   <= 1'b0;
      togSeen_r <= 1'b0;
      hwS1_r    <= 1'b1;
      hwS2_r    <= 1'b1;
    end else if (ce) begin
      csS1_r    <= csN;
      csS2_r    <= csS1_r;
      csPrev_r  <= csS2_r;
      togS1_r   <= frmTog_r;
      togS2_r   <= togS1_r;
      hwS1_r    <= hwResetN;
      hwS2_r    <= hwS1_r;
      if (csRise) togSeen_r <= togS2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hwCnt_r   <= 3'd0;
      spoiled_r <= 1'b0;
    end else if (ce) begin
      if (hwEn && !hwS2_r) hwCnt_r <= hwHold ? hwCnt_r : hwCnt_r + 3'd1;
      else                 hwCnt_r <= 3'd0;
      if (hwHold)      spoiled_r <= 1'b1;
      else if (csRise) spoiled_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r        <= 1'b0;
      volCfg_r       <= VOLCFG_RESET;
      readParamRst_r <= 1'b0;
      wel_r          <= 1'b0;
    end else if (ce) begin
      if (frmOk) armed_r <= armSet;
      if (swFire) volCfg_r <= nvCfg;
      // continuous read and power down live elsewhere and are not touched here
      readParamRst_r <= hwHold | swFire;
      if (abort || startErase || startProg) wel_r <= 1'b0;
      else if (weSet)                       wel_r <= 1'b1;
    end
  end

  assign wasWrite = (state_r == ST_ERASE) || (state_r == ST_PROG);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      timer_r   <= '0;
      idx_r     <= '0;
      progN_r   <= '0;
      progLow_r <= '0;
      page_r    <= '0;
      region_r  <= 2'd1;
    end else if (ce) begin
      idx_r <= (idx_r == REGION_LAST) ? idx_r : idx_r + 10'd1;
      if (timer_r != '0) timer_r <= timer_r - 32'd1;
      if (abort) begin
        // abort with longer recovery after a write or when already in recovery
        state_r <= ST_RECOV;
        timer_r <= (wasWrite || state_r == ST_RECOV) ? REC_WR_CYC : REC_CYC;
      end else if (startErase || startProg) begin
        state_r   <= startErase ? ST_ERASE : ST_PROG;
        timer_r   <= startErase ? ERASE_CYCLES : PROG_CYCLES;
        idx_r     <= '0;
        region_r  <= frmRegion;
        page_r    <= frmAddr[9:8];
        progN_r   <= keepBytes;
        progLow_r <= 8'(frmAddr[7:0] + 8'(frmBytes - keepBytes));
      end else if (state_r != ST_IDLE && timer_r == '0
                   && (state_r != ST_ERASE || idx_r == REGION_LAST)) begin
        state_r <= ST_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (memWe) regionMem[memAddr] <= memWData;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)  rdData_r <= 8'h00;
    else if (ce) rdData_r <= regionMem[rdAddr];
  end

  assign ioOe           = hwHold ? 4'h0 : oeLink_r;
  assign ioOut          = outNib_r;
  assign volCfg         = volCfg_r;
  assign readParamRst   = readParamRst_r;
  assign busyFlag       = (state_r != ST_IDLE);
  assign writeLatchFlag = wel_r;
  assign rdData         = rdData_r;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rejectBusy;
    (startErase || startProg) |-> !extBusy && $past(state_r) == ST_IDLE;
  endproperty
  a_rejectBusy: assert property (p_rejectBusy) else $error("cycle started while busy");

  property p_needLatch;
    (startErase || startProg) |-> wel_r ##1 !wel_r;
  endproperty
  a_needLatch: assert property (p_needLatch) else $error("write latch misuse");

  property p_lockRespected;
    (startErase || startProg) |-> lockVec[2'(frmRegion - 2'd1)] == 1'b0;
  endproperty
  a_lockRespected: assert property (p_lockRespected) else $error("locked region written");

  property p_eraseLen;
    startErase |-> frmBits == 12'h020 && frmRegion != 2'd0;
  endproperty
  a_eraseLen: assert property (p_eraseLen) else $error("erase frame length wrong");

  property p_eraseBusy;
    (startErase && !abort) |=> busyFlag && state_r == ST_ERASE ##1 busyFlag;
  endproperty
  a_eraseBusy: assert property (p_eraseBusy) else $error("erase busy missing");

  property p_disarm;
    (frmOk && armed_r && frmOp != OP_RESET_ARM) |=> !armed_r;
  endproperty
  a_disarm: assert property (p_disarm) else $error("reset arm not cleared");

  property p_reload;
    swFire |=> volCfg_r == $past(nvCfg) && readParamRst_r;
  endproperty
  a_reload: assert property (p_reload) else $error("config not reloaded");

  property p_hwPulse;
    (ce && hwEn && !hwS2_r)[*4] |=> hwHold;
  endproperty
  a_hwPulse: assert property (p_hwPulse) else $error("hardware reset not taken");

  property p_abortWrite;
    (hwHold && ce && (state_r == ST_ERASE || state_r == ST_PROG))
      |=> state_r == ST_RECOV && timer_r >= 32'(REC_CYC) && ioOe == 4'h0;
  endproperty
  a_abortWrite: assert property (p_abortWrite) else $error("write not aborted");

  c_erase: cover property (startErase ##[1:1000] state_r == ST_ERASE);
  c_prog:  cover property (startProg ##1 busyFlag);
  c_fire:  cover property (armSet ##[1:1000] swFire);
  c_hw:    cover property (hwHold && busyFlag);
endmodule // fsr_ctrl

// file: sim/fsr_host.sv
// host serial controller model: whole frames on the link, clock still between frames
`timescale 1ns/10ps
module fsr_host (
  output logic            sck,   // link clock, 6 ns period inside frames
  output logic            csN,   // chip select, active low
  output logic      [3:0] ioIn,  // data toward the device
  input  wire logic [3:0] ioOut, // data from the device
  input  wire logic [3:0] ioOe   // device drive enables
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    ioIn = 4'hF;
  end
  task automatic frame(input logic [63:0] tx, input int nBits, input int nRd,
                       output logic [7:0] rd, output logic oeOk);
    rd = 8'h00;
    oeOk = 1'b1;
    csN = 1'b0;
    #4;
    for (int i = 0; i < nBits + nRd; i++) begin
      // idle data bits toggle so a stale value is never read back as valid
      ioIn[0] = (i < nBits) ? tx[63-i] : i[0];
      #3 sck = 1'b1;
      if (i >= nBits) begin
        rd = {rd[6:0], ioOut[1]};
        oeOk = oeOk & (ioOe === 4'h2);
      end
      #3 sck = 1'b0;
    end
    #2 csN = 1'b1;
    ioIn = {3'h7, ~ioIn[0]};
    #1 oeOk = oeOk & (ioOe === 4'h0);
    #250;
  endtask
endmodule // fsr_host

// file: sim/fsr_ctrl_tb.sv
// self-checking bench for the region, reset and table command block
`timescale 1ns/10ps
module fsr_ctrl_tb;
  import fsr_pkg::*;
  logic        clk, rst_n, sck, csN, hwResetN, quadIoEnable, extBusy, ok;
  logic        ce, qpiMode, pinSelReset, dedRstDisable;
  logic        readParamRst, busyFlag, writeLatchFlag;
  logic [3:0]  ioIn, ioOut, ioOe;
  logic [15:0] sr2In;
  logic [7:0]  nvCfg, volCfg, rdData, rd, d0, d1, v;
  logic [11:0] rdAddr;
  logic [63:0] tx;
  logic [9:0]  off;
  int          mismatches, comparisons, cycles;
  localparam logic [63:0] WL = {OP_WRITE_LATCH_SET, 56'h0};

  fsr_ctrl #(.ERASE_CYCLES(1100), .PROG_CYCLES(300), .DEDICATED_RST(1'b1)) dut_u (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sck(sck), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe(ioOe), .qpiMode(qpiMode), .quadIoEnable(quadIoEnable), .pinSelReset(pinSelReset),
    .dedRstDisable(dedRstDisable), .hwResetN(hwResetN), .sr2In(sr2In), .extBusy(extBusy),
    .nvCfg(nvCfg), .volCfg(volCfg), .readParamRst(readParamRst), .busyFlag(busyFlag),
    .writeLatchFlag(writeLatchFlag), .rdAddr(rdAddr), .rdData(rdData));
  fsr_host host_u (.sck(sck), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // run needs about 7000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chkVal(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chkFlag(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  // frame image: opcode, region address, one data byte
  function automatic logic [63:0] cmd(input logic [7:0] op, input int r,
                                      input logic [9:0] o, input logic [7:0] dat);
    return {op, 8'h00, 4'(r), 2'b00, o, dat, 24'h0};
  endfunction
  task automatic send(input logic [63:0] t, input int n);
    host_u.frame(t, n, 0, rd, ok);
  endtask
  task automatic readMem(input int r, input logic [9:0] o);
    rdAddr = 12'((r - 1) * 1024 + int'(o));
    tick(2);
    v = rdData;
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 3000 && busyFlag !== 1'b0; i++) tick();
    chkFlag(busyFlag, 1'b0, "busy end");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    qpiMode = 1'b0;
    pinSelReset = 1'b0;
    dedRstDisable = 1'b0;
    hwResetN = 1'b1;
    quadIoEnable = 1'b0;
    extBusy = 1'b0;
    sr2In = 16'h0000;
    nvCfg = 8'h00;
    rdAddr = 12'h000;
    void'($urandom(32'h5B56));
    tick(2);
    rst_n = 1'b1;
    tick(2);
    host_u.frame({OP_PARAM_READ, 16'h0, 8'($urandom_range(255, 16)), 32'h0}, 40, 8, rd, ok);
    chkVal(rd, UNDEF_BYTE, "table");
    chkFlag(ok, 1'b1, "out enable");
    $display("test table read done");
    for (int r = 1; r <= 3; r++) begin
      off = (r == 3) ? REGION_LAST : 10'($urandom);
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      send(WL, 8);
      chkFlag(writeLatchFlag, 1'b1, "latch set");
      send(cmd(OP_REGION_ERASE, r, off, 8'h00), 32);
      chkFlag(busyFlag, 1'b1, "erase busy");
      chkFlag(writeLatchFlag, 1'b0, "erase latch");
      waitIdle();
      readMem(r, off);
      chkVal(v, ERASED_BYTE, "erased");
      for (int p = 0; p < 2; p++) begin
        send(WL, 8);
        send(cmd(OP_REGION_PROG, r, off, p ? d1 : d0), 40);
        chkFlag(busyFlag, 1'b1, "prog busy");
        waitIdle();
      end
      readMem(r, off);
      chkVal(v, d0 & d1, "program");
    end
    $display("test erase program done");
    for (int k = 0; k < 5; k++) begin
      sr2In = (k == 1) ? 16'h3800 : 16'h0000;
      extBusy = (k == 4);
      if (k == 1) send(WL, 8);
      tx = cmd((k == 2) ? OP_REGION_ERASE : OP_REGION_PROG, k % 3 + 1, 10'h000, 8'h00);
      if (k == 3) tx[43:42] = 2'b01;
      send(tx, 40);
      chkFlag(busyFlag, 1'b0, "refused");
      chkFlag(writeLatchFlag, k != 0, "latch kept");
    end
    extBusy = 1'b0;
    sr2In = 16'h0000;
    send(WL, 8);
    send(cmd(OP_REGION_ERASE, 3, 10'h000, 8'h00), 32);
    send(WL, 8);
    send(cmd(OP_REGION_PROG, 3, 10'h001, 8'h00), 40);
    chkFlag(writeLatchFlag, 1'b0, "latch while busy");
    waitIdle();
    readMem(3, 10'h001);
    chkVal(v, ERASED_BYTE, "busy reject");
    $display("test refusals done");
    dedRstDisable = 1'b1;
    hwResetN = 1'b0;
    tick(8);
    chkFlag(readParamRst, 1'b0, "pin disabled");
    hwResetN = 1'b1;
    tick(4);
    dedRstDisable = 1'b0;
    quadIoEnable = 1'b1;
    hwResetN = 1'b0;
    // two sync stages, four counted cycles, one register stage
    tick(8);
    chkFlag(readParamRst, 1'b1, "hw held");
    host_u.frame({OP_PARAM_READ, 56'h0}, 40, 8, rd, ok);
    chkFlag(ok, 1'b0, "tristate");
    send(WL, 8);
    hwResetN = 1'b1;
    tick(4);
    chkFlag(writeLatchFlag, 1'b0, "inputs ignored");
    waitIdle();
    $display("test hardware reset done");
    nvCfg = 8'($urandom) | 8'h01;
    send({OP_RESET_ARM, 56'h0}, 8);
    send(WL, 8);
    send({OP_RESET_FIRE, 56'h0}, 8);
    chkVal(volCfg, VOLCFG_RESET, "disarmed");
    send({OP_RESET_ARM, 56'h0}, 8);
    send({OP_RESET_FIRE, 56'h0}, 8);
    chkVal(volCfg, nvCfg, "sw reset");
    waitIdle();
    $display("test software reset done");
    give_verdict();
  end
endmodule // fsr_ctrl_tb
